// [design/eau_pkg.sv]
package eau_pkg;
  // op word layout: leading four bits are the op field
  localparam int OPF_LSB = 12;
  localparam int OPF_W = 4;
  localparam int MODE_LSB = 8;
  localparam int MODE_W = 4;
  localparam int SIZE_LSB = 6;
  localparam int BITN_LSB = 4;
  localparam int TVEC_LSB = 4;
  localparam int RF_LSB = 0;
  localparam int RF_W = 4;
  localparam int AR_W = 3;
  // instruction classes
  localparam logic [3:0] CLS_MOV = 4'h0;
  localparam logic [3:0] CLS_ALU = 4'h1;
  localparam logic [3:0] CLS_BIT = 4'h2;
  localparam logic [3:0] CLS_BCC = 4'h3;
  localparam logic [3:0] CLS_BSR = 4'h4;
  localparam logic [3:0] CLS_JMP = 4'h5;
  localparam logic [3:0] CLS_JSR = 4'h6;
  localparam logic [3:0] CLS_TRAP = 4'h7;
  // addressing modes
  localparam logic [3:0] M_RD = 4'h0;
  localparam logic [3:0] M_RIND = 4'h1;
  localparam logic [3:0] M_D16 = 4'h2;
  localparam logic [3:0] M_D32 = 4'h3;
  localparam logic [3:0] M_PINC = 4'h4;
  localparam logic [3:0] M_PDEC = 4'h5;
  localparam logic [3:0] M_A8 = 4'h6;
  localparam logic [3:0] M_A16 = 4'h7;
  localparam logic [3:0] M_A24 = 4'h8;
  localparam logic [3:0] M_A32 = 4'h9;
  localparam logic [3:0] M_I8 = 4'ha;
  localparam logic [3:0] M_I16 = 4'hb;
  localparam logic [3:0] M_I32 = 4'hc;
  localparam logic [3:0] M_PC8 = 4'hd;
  localparam logic [3:0] M_PC16 = 4'he;
  localparam logic [3:0] M_MIND = 4'hf;
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  localparam logic [31:0] STEP_B = 32'h1;
  localparam logic [31:0] STEP_W = 32'h2;
  localparam logic [31:0] STEP_L = 32'h4;
  localparam logic [1:0] K_REG = 2'h0;
  localparam logic [1:0] K_IMM = 2'h1;
  localparam logic [1:0] K_MEM = 2'h2;
  localparam logic [1:0] K_BR = 2'h3;
  localparam logic [23:0] ABS8_FILL = 24'hffffff;
  localparam logic [7:0] PROG_HI = 8'h00;
  localparam logic [23:0] MIND_HI = 24'h000000;
  // register map
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_LEA = 4'h8;
  localparam logic [3:0] A_CNT = 4'hc;
  localparam logic CTRL_EN_RST = 1'b1;
  typedef enum logic [2:0] {S_IDLE, S_DEC, S_WREG, S_CALC, S_WMEM} eau_st_t;
endpackage

// [design/eau_if.sv]
interface eau_if;
  logic [15:0] op;
  logic [3:0] cls;
  logic [3:0] mode;
  logic [1:0] size;
  logic legal;
  logic needs_reg;
  logic prog;
  logic [1:0] ext_w;
  modport top(output op, input cls, mode, size, legal, needs_reg, prog, ext_w);
  modport dec(input op, output cls, mode, size, legal, needs_reg, prog, ext_w);
  modport calc(input mode, size, prog);
endinterface

// [design/eau_dec.sv]
module eau_dec (
  eau_if.dec d // op word in, decoded fields out
);
  always_comb begin
    d.cls = d.op[eau_pkg::OPF_LSB +: eau_pkg::OPF_W];
    d.mode = d.op[eau_pkg::MODE_LSB +: eau_pkg::MODE_W];
    d.size = d.op[eau_pkg::SIZE_LSB +: 2];
    // bit ops reuse the size bits for the bit number, so size is byte
    if (d.cls == eau_pkg::CLS_BIT) begin
      d.size = eau_pkg::SZ_B;
    end
    d.prog = (d.cls == eau_pkg::CLS_BCC) || (d.cls == eau_pkg::CLS_BSR) ||
             (d.cls == eau_pkg::CLS_JMP) || (d.cls == eau_pkg::CLS_JSR);
    d.needs_reg = (d.mode == eau_pkg::M_RIND) || (d.mode == eau_pkg::M_D16) ||
                  (d.mode == eau_pkg::M_D32) || (d.mode == eau_pkg::M_PINC) ||
                  (d.mode == eau_pkg::M_PDEC);
    // extension words after the opcode word
    case (d.mode)
      eau_pkg::M_D16, eau_pkg::M_A16, eau_pkg::M_I16, eau_pkg::M_PC16: d.ext_w = 2'h1;
      eau_pkg::M_D32, eau_pkg::M_A24, eau_pkg::M_A32, eau_pkg::M_I32: d.ext_w = 2'h2;
      default: d.ext_w = 2'h0;
    endcase
    case (d.cls)
      eau_pkg::CLS_MOV: d.legal = (d.mode != eau_pkg::M_PC8) && (d.mode != eau_pkg::M_PC16) &&
                                 (d.mode != eau_pkg::M_MIND) &&
                                 (d.mode != eau_pkg::M_A24);
      eau_pkg::CLS_ALU: d.legal = (d.mode == eau_pkg::M_RD) || (d.mode == eau_pkg::M_I8) ||
                                 (d.mode == eau_pkg::M_I16) ||
                                 (d.mode == eau_pkg::M_I32);
      eau_pkg::CLS_BIT: d.legal = (d.mode == eau_pkg::M_RD) || (d.mode == eau_pkg::M_RIND) ||
                                 (d.mode == eau_pkg::M_A8) || (d.mode == eau_pkg::M_A16) ||
                                 (d.mode == eau_pkg::M_A32);
      eau_pkg::CLS_BCC, eau_pkg::CLS_BSR: d.legal = (d.mode == eau_pkg::M_PC8) ||
                                                   (d.mode == eau_pkg::M_PC16);
      eau_pkg::CLS_JMP, eau_pkg::CLS_JSR: d.legal = (d.mode == eau_pkg::M_RIND) ||
                                                   (d.mode == eau_pkg::M_A24) ||
                                                   (d.mode == eau_pkg::M_MIND);
      eau_pkg::CLS_TRAP: d.legal = (d.mode == eau_pkg::M_RD);
      default: d.legal = 1'b0;
    endcase
    // size code 3 has no meaning
    if (d.size == 2'h3) begin
      d.legal = 1'b0;
    end
  end
endmodule

// [design/eau_calc.sv]
module eau_calc (
  eau_if.calc d, // decoded fields
  input wire logic [31:0] rv, // address register value
  input wire logic [31:0] ext, // extension field
  input wire logic [31:0] md, // memory indirect operand
  input wire logic [23:0] pc, // next instruction address
  output logic [31:0] ea, // effective address
  output logic [31:0] wb, // register write-back value
  output logic [31:0] imm, // immediate operand
  output logic [31:0] ptr // memory indirect pointer
);
  always_comb begin
    logic [31:0] step;
    logic [31:0] sx8;
    logic [31:0] sx16;
    logic [23:0] br;
    step = (d.size == eau_pkg::SZ_L) ? eau_pkg::STEP_L :
           (d.size == eau_pkg::SZ_W) ? eau_pkg::STEP_W : eau_pkg::STEP_B;
    sx8 = {{24{ext[7]}}, ext[7:0]};
    sx16 = {{16{ext[15]}}, ext[15:0]};
    br = pc;
    ea = rv;
    wb = rv;
    imm = ext;
    // longword pointer, so even
    ptr = {eau_pkg::MIND_HI, ext[7:1], 1'b0};
    case (d.mode)
      eau_pkg::M_RIND: ea = rv;
      eau_pkg::M_D16: ea = rv + sx16;
      eau_pkg::M_D32: ea = rv + ext;
      eau_pkg::M_PINC: wb = rv + step;
      eau_pkg::M_PDEC: begin
        ea = rv - step;
        wb = rv - step;
      end
      eau_pkg::M_A8: ea = {eau_pkg::ABS8_FILL, ext[7:0]};
      eau_pkg::M_A16: ea = sx16;
      eau_pkg::M_A24: ea = {eau_pkg::PROG_HI, ext[23:0]};
      eau_pkg::M_A32: ea = ext;
      eau_pkg::M_I8: imm = {24'h000000, ext[7:0]};
      eau_pkg::M_I16: imm = {16'h0000, ext[15:0]};
      eau_pkg::M_PC8: begin
        br = pc + sx8[23:0];
        ea = {eau_pkg::PROG_HI, br};
      end
      eau_pkg::M_PC16: begin
        br = pc + sx16[23:0];
        ea = {eau_pkg::PROG_HI, br};
      end
      eau_pkg::M_MIND: ea = {eau_pkg::PROG_HI, md[23:0]};
      default: ea = rv;
    endcase
    if (d.prog) begin
      ea[31:24] = eau_pkg::PROG_HI;
    end
    if (d.prog || (d.size != eau_pkg::SZ_B && d.mode != eau_pkg::M_RD)) begin
      ea[0] = 1'b0;
    end
  end
endmodule

// [design/eau_top.sv]
// Contract
// - instructions are whole 16-bit words
// - leading four bits form the op field
// - 3-bit address, 3/4-bit data register fields
// - extension gives 8/16/32-bit immediate, address, displacement
// - register direct: byte, word or long register
// - register program address keeps low 24 bits
// - displacement added, 16-bit one sign-extended
// - post-increment uses register, then adds 1/2/4
// - pre-decrement subtracts 1/2/4, uses and stores result
// - 8-bit absolute fills upper bits with ones
// - 16-bit absolute is sign-extended
// - 24-bit absolute only for program, upper zero
// - 32-bit absolute reaches the whole space
// - 8/16/32 immediates, 3-bit bit number, 2-bit trap
// - pc-relative adds sign-extended offset, 24-bit target
// - pc used is next instruction address
// - memory indirect pointer zero-extended to 0..ff; here bit zero is cleared, so only even 0..fe
// - indirect operand top byte taken as zero
// - word/long/branch odd address drops bit zero
// - transfer and arithmetic classes limit their modes
// - pc-relative for branches, indirect for jumps
//
// Chosen here: the address map and the address-and-strobe port.
module eau_top (
  input wire logic REF_CLK, // system clock
  input wire logic RST_B, // sync reset, active low
  input wire logic REQ, // decode request pulse
  input wire logic [15:0] OP_WORD, // opcode word
  input wire logic [31:0] EXT, // extension field, low aligned
  input wire logic [23:0] PC_NEXT, // address of next instruction
  input wire logic [31:0] REG_VAL, // register value, cycle after REG_RD
  input wire logic [31:0] MEM_RD_DATA, // indirect operand
  input wire logic MEM_RD_VALID, // indirect operand valid
  input wire logic [3:0] ADDR, // register bus address
  input wire logic [31:0] WDATA, // register bus write data
  input wire logic WR, // register bus write strobe
  input wire logic RD, // register bus read strobe
  output logic BUSY, // request in progress
  output logic REG_RD, // address register read pulse
  output logic [2:0] REG_INDEX, // address register number
  output logic MEM_RD, // indirect operand read pulse
  output logic [31:0] MEM_ADDR, // indirect operand address
  output logic EA_VALID, // result pulse
  output logic [1:0] EA_KIND, // register, immediate, operand, branch
  output logic [31:0] EA_ADDR, // effective address
  output logic [1:0] EA_SIZE, // access size
  output logic [31:0] IMM_DATA, // immediate operand
  output logic [3:0] REG_FIELD, // register direct field
  output logic [2:0] BIT_NUM, // bit number
  output logic [1:0] TRAP_VEC, // trap vector select
  output logic [1:0] INSN_LEN, // instruction length in words
  output logic WB_VALID, // register write-back pulse
  output logic [2:0] WB_INDEX, // write-back register
  output logic [31:0] WB_DATA, // write-back value
  output logic ILLEGAL, // mode not allowed pulse
  output logic [31:0] RDATA // register bus read data
);
  typedef struct packed {
    eau_pkg::eau_st_t st;
    logic [15:0] op;
    logic [31:0] ext;
    logic [23:0] pc;
    logic busy;
    logic reg_rd;
    logic mem_rd;
    logic [31:0] mem_a;
    logic ea_v;
    logic [1:0] kind;
    logic [31:0] ea;
    logic [1:0] sz;
    logic [31:0] imm;
    logic [1:0] len;
    logic wb_v;
    logic [31:0] wb;
    logic ill;
    logic [31:0] rdata;
    logic en;
    logic [31:0] lea;
    logic [3:0] lmode;
    logic [3:0] lcls;
    logic lill;
    logic [15:0] dcnt;
    logic [15:0] icnt;
  } eau_state_t;

  eau_state_t state_reg;
  eau_state_t state_next;
  logic [31:0] ea_c;
  logic [31:0] wb_c;
  logic [31:0] imm_c;
  logic [31:0] ptr_c;

  eau_if d ();
  assign d.op = state_reg.op;

  eau_dec u_dec (
    .d(d)
  );

  eau_calc u_calc (
    .d(d),
    .rv(REG_VAL),
    .ext(state_reg.ext),
    .md(MEM_RD_DATA),
    .pc(state_reg.pc),
    .ea(ea_c),
    .wb(wb_c),
    .imm(imm_c),
    .ptr(ptr_c)
  );

  always_comb begin
    logic fin;
    fin = 1'b0;
    state_next = state_reg;
    state_next.reg_rd = 1'b0;
    state_next.mem_rd = 1'b0;
    state_next.ea_v = 1'b0;
    state_next.wb_v = 1'b0;
    state_next.ill = 1'b0;
    state_next.rdata = '0;
    if (RD) begin
      case (ADDR)
        eau_pkg::A_CTRL: state_next.rdata = {31'h0, state_reg.en};
        eau_pkg::A_STAT: state_next.rdata = {15'h0, state_reg.lill, 4'h0,
                                             state_reg.lcls, state_reg.lmode,
                                             3'h0, state_reg.busy};
        eau_pkg::A_LEA: state_next.rdata = state_reg.lea;
        eau_pkg::A_CNT: state_next.rdata = {state_reg.icnt, state_reg.dcnt};
        default: state_next.rdata = '0;
      endcase
    end
    if (WR && ADDR == eau_pkg::A_CTRL) begin
      state_next.en = WDATA[0];
    end
    if (WR && ADDR == eau_pkg::A_CNT) begin
      // a write clears both counters; a decode ending that cycle still adds one to its counter's old value
      state_next.dcnt = '0;
      state_next.icnt = '0;
    end
    case (state_reg.st)
      eau_pkg::S_IDLE: begin
        // disabled unit ignores requests; the fetch side sees BUSY low
        if (REQ && state_reg.en) begin
          state_next.op = OP_WORD;
          state_next.ext = EXT;
          state_next.pc = PC_NEXT;
          state_next.busy = 1'b1;
          state_next.st = eau_pkg::S_DEC;
        end
      end
      eau_pkg::S_DEC: begin
        if (!d.legal) begin
          state_next.ill = 1'b1;
          state_next.lill = 1'b1;
          state_next.lmode = d.mode;
          state_next.lcls = d.cls;
          state_next.icnt = state_reg.icnt + 16'h1;
          state_next.busy = 1'b0;
          state_next.st = eau_pkg::S_IDLE;
        end else if (d.needs_reg && d.cls != eau_pkg::CLS_TRAP) begin
          state_next.reg_rd = 1'b1;
          state_next.st = eau_pkg::S_WREG;
        end else if (d.mode == eau_pkg::M_MIND) begin
          state_next.mem_rd = 1'b1;
          state_next.mem_a = ptr_c;
          state_next.st = eau_pkg::S_WMEM;
        end else begin
          fin = 1'b1;
        end
      end
      eau_pkg::S_WREG: begin
        state_next.st = eau_pkg::S_CALC;
      end
      eau_pkg::S_CALC: begin
        fin = 1'b1;
      end
      eau_pkg::S_WMEM: begin
        // no timeout: the sequencer always answers an indirect read
        if (MEM_RD_VALID) begin
          fin = 1'b1;
        end
      end
      default: begin
        state_next.st = eau_pkg::S_IDLE;
        state_next.busy = 1'b0;
      end
    endcase
    if (fin) begin
      // address, size and write-back leave on one edge
      state_next.ea_v = 1'b1;
      state_next.ea = ea_c;
      state_next.sz = d.size;
      state_next.imm = imm_c;
      state_next.len = d.ext_w + 2'h1;
      state_next.wb = wb_c;
      state_next.wb_v = (d.mode == eau_pkg::M_PINC) ||
                        (d.mode == eau_pkg::M_PDEC);
      if (d.prog) begin
        state_next.kind = eau_pkg::K_BR;
      end else if (d.mode == eau_pkg::M_RD) begin
        state_next.kind = eau_pkg::K_REG;
      end else if (d.mode == eau_pkg::M_I8 || d.mode == eau_pkg::M_I16 ||
                   d.mode == eau_pkg::M_I32) begin
        state_next.kind = eau_pkg::K_IMM;
      end else begin
        state_next.kind = eau_pkg::K_MEM;
      end
      state_next.lea = ea_c;
      state_next.lmode = d.mode;
      state_next.lcls = d.cls;
      state_next.lill = 1'b0;
      state_next.dcnt = state_reg.dcnt + 16'h1;
      state_next.busy = 1'b0;
      state_next.st = eau_pkg::S_IDLE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state_reg <= '0;
      state_reg.st <= eau_pkg::S_IDLE;
      state_reg.en <= eau_pkg::CTRL_EN_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign BUSY = state_reg.busy;
  assign REG_RD = state_reg.reg_rd;
  assign REG_INDEX = state_reg.op[eau_pkg::RF_LSB +: eau_pkg::AR_W];
  assign MEM_RD = state_reg.mem_rd;
  assign MEM_ADDR = state_reg.mem_a;
  assign EA_VALID = state_reg.ea_v;
  assign EA_KIND = state_reg.kind;
  assign EA_ADDR = state_reg.ea;
  assign EA_SIZE = state_reg.sz;
  assign IMM_DATA = state_reg.imm;
  assign REG_FIELD = state_reg.op[eau_pkg::RF_LSB +: eau_pkg::RF_W];
  assign BIT_NUM = state_reg.op[eau_pkg::BITN_LSB +: 3];
  assign TRAP_VEC = state_reg.op[eau_pkg::TVEC_LSB +: 2];
  assign INSN_LEN = state_reg.len;
  assign WB_VALID = state_reg.wb_v;
  assign WB_INDEX = state_reg.op[eau_pkg::RF_LSB +: eau_pkg::AR_W];
  assign WB_DATA = state_reg.wb;
  assign ILLEGAL = state_reg.ill;
  assign RDATA = state_reg.rdata;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  chk_wb_with_ea: assert property (WB_VALID |-> EA_VALID && EA_KIND == eau_pkg::K_MEM)
    else $error("write-back without its address");

  chk_postinc_byte_step: assert property (
    EA_VALID && d.mode == eau_pkg::M_PINC && EA_SIZE == eau_pkg::SZ_B
    |-> WB_VALID && WB_DATA == EA_ADDR + eau_pkg::STEP_B)
    else $error("post-increment step wrong");

  chk_predec_addr_wb: assert property (
    EA_VALID && d.mode == eau_pkg::M_PDEC |-> WB_VALID && WB_DATA[31:1] == EA_ADDR[31:1])
    else $error("pre-decrement address differs from stored value");

  chk_branch_upper_zero: assert property (
    EA_VALID && EA_KIND == eau_pkg::K_BR |-> EA_ADDR[31:24] == eau_pkg::PROG_HI && !EA_ADDR[0])
    else $error("branch target upper byte or bit zero set");

  chk_abs8_ones: assert property (
    EA_VALID && d.mode == eau_pkg::M_A8 |-> EA_ADDR[31:8] == eau_pkg::ABS8_FILL)
    else $error("short absolute upper bits not ones");

  chk_abs16_sign: assert property (
    EA_VALID && d.mode == eau_pkg::M_A16 |-> EA_ADDR[31:16] == {16{EA_ADDR[15]}})
    else $error("16-bit absolute not sign-extended");

  chk_even_access: assert property (
    EA_VALID && EA_KIND == eau_pkg::K_MEM && EA_SIZE != eau_pkg::SZ_B |-> !EA_ADDR[0])
    else $error("word or long access at odd address");

  chk_transfer_modes: assert property (
    state_reg.st == eau_pkg::S_DEC && d.cls == eau_pkg::CLS_MOV &&
    (d.mode == eau_pkg::M_PC8 || d.mode == eau_pkg::M_MIND) |=> ILLEGAL && !EA_VALID)
    else $error("transfer accepted a branch mode");

  chk_branch_modes: assert property (
    state_reg.st == eau_pkg::S_DEC && d.cls == eau_pkg::CLS_BCC &&
    d.mode != eau_pkg::M_PC8 && d.mode != eau_pkg::M_PC16 |=> ILLEGAL)
    else $error("conditional branch accepted a non-relative mode");

  chk_reg_latency: assert property (REG_RD |-> !EA_VALID ##2 EA_VALID)
    else $error("result not two cycles after register read");

  chk_mind_pointer: assert property (
    MEM_RD |-> MEM_ADDR[31:8] == eau_pkg::MIND_HI && !MEM_ADDR[0] ##1 BUSY)
    else $error("indirect pointer out of first page");

  cov_post_inc: cover property (EA_VALID && WB_VALID && d.mode == eau_pkg::M_PINC);
  cov_mem_ind: cover property (MEM_RD ##[1:8] EA_VALID);
  cov_illegal: cover property (ILLEGAL);
  cov_pc_rel: cover property (EA_VALID && d.mode == eau_pkg::M_PC16);
endmodule

// [testbench/eau_partner.sv]
module eau_partner (
  input wire logic REF_CLK, // system clock
  input wire logic REG_RD, // register read pulse
  input wire logic [2:0] REG_INDEX, // register to read
  input wire logic WB_VALID, // write-back pulse
  input wire logic [2:0] WB_INDEX, // register to write
  input wire logic [31:0] WB_DATA, // value to write
  input wire logic MEM_RD, // operand read pulse
  output logic [31:0] REG_VAL, // register value
  output logic MEM_RD_VALID, // operand valid
  output logic [31:0] MEM_RD_DATA // operand data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [8];
  logic [31:0] mem_val = 32'h0;
  int mem_delay = 0;
  int cnt = 0;
  initial begin
    REG_VAL = 32'h0;
    MEM_RD_VALID = 1'b0;
    MEM_RD_DATA = 32'h0;
  end
  // data flips outside its valid cycle so a sample one cycle late never matches by luck
  always @(posedge REF_CLK) begin
    REG_VAL <= REG_RD ? regs[REG_INDEX] : ~REG_VAL;
    MEM_RD_DATA <= ~MEM_RD_DATA;
    MEM_RD_VALID <= 1'b0;
    if (WB_VALID) regs[WB_INDEX] <= WB_DATA;
    cnt <= MEM_RD ? mem_delay : (cnt > 0 ? cnt - 1 : 0);
    if ((MEM_RD && mem_delay == 0) || cnt == 1) begin
      MEM_RD_VALID <= 1'b1;
      MEM_RD_DATA <= mem_val;
    end
  end
endmodule

// [testbench/effective_address_unit_bench.sv]
module effective_address_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_b = 1'b0, req = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] op = 16'h0;
  logic [31:0] ext = 32'h0, wdata = 32'h0;
  logic [23:0] pc = 24'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] reg_val, mem_data, mem_addr, ea_addr, imm_data, wb_data, rdata;
  logic mem_valid, busy, reg_rd, mem_rd, ea_valid, wb_valid, illegal, ill, wbv, bz;
  logic [2:0] reg_index, bit_num, wb_index, ridx;
  logic [1:0] ea_kind, ea_size, trap_vec, insn_len;
  logic [3:0] reg_field;
  logic [31:0] maddr, last_ea, rb;
  int n_tests = 0, n_mismatch = 0, lat = 0, mdel = 0;
  always #4 ref_clk = ~ref_clk;
  eau_top dut (.REF_CLK(ref_clk), .RST_B(rst_b), .REQ(req), .OP_WORD(op), .EXT(ext),
    .PC_NEXT(pc), .REG_VAL(reg_val), .MEM_RD_DATA(mem_data), .MEM_RD_VALID(mem_valid),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .BUSY(busy), .REG_RD(reg_rd),
    .REG_INDEX(reg_index), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .EA_VALID(ea_valid),
    .EA_KIND(ea_kind), .EA_ADDR(ea_addr), .EA_SIZE(ea_size), .IMM_DATA(imm_data),
    .REG_FIELD(reg_field), .BIT_NUM(bit_num), .TRAP_VEC(trap_vec), .INSN_LEN(insn_len),
    .WB_VALID(wb_valid), .WB_INDEX(wb_index), .WB_DATA(wb_data), .ILLEGAL(illegal),
    .RDATA(rdata));
  eau_partner part (.REF_CLK(ref_clk), .REG_RD(reg_rd), .REG_INDEX(reg_index),
    .WB_VALID(wb_valid), .WB_INDEX(wb_index), .WB_DATA(wb_data), .MEM_RD(mem_rd),
    .REG_VAL(reg_val), .MEM_RD_VALID(mem_valid), .MEM_RD_DATA(mem_data));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_val(logic [31:0] got, logic [31:0] exp, string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp_lat(int got, int exp, string m);
    n_tests++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD %0t %s took %0d exp %0d", $time, m, got, exp);
    end
  endtask
  task automatic bus_wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic do_op(logic [15:0] o, logic [31:0] e, logic [23:0] p);
    @(posedge ref_clk);
    op <= o;
    ext <= e;
    pc <= p;
    req <= 1'b1;
    lat = 0;
    ridx = 'x;
    maddr = 'x;
    for (int i = 1; i < 40 && lat == 0; i++) begin
      @(posedge ref_clk);
      req <= 1'b0;
      #1;
      if (i == 1) bz = busy;
      if (reg_rd) ridx = reg_index;
      if (mem_rd) maddr = mem_addr;
      if (ea_valid || illegal) begin
        lat = i;
        ill = illegal;
        wbv = wb_valid;
      end
    end
    if (lat == 0) begin
      cmp_val(32'h0, 32'h1, "no result");
      complete_run;
    end
  endtask
  task automatic run_op(logic [3:0] c, logic [3:0] m, logic [3:0] f, logic [3:0] r,
      logic [31:0] e, logic [23:0] p);
    logic [31:0] rv, st, ea, wb, im;
    logic [1:0] k, s;
    logic br, rm;
    @(posedge ref_clk);
    #1;
    part.mem_delay = mdel;
    s = c == eau_pkg::CLS_BIT ? eau_pkg::SZ_B : f[3:2];
    rv = part.regs[r[2:0]];
    st = s == eau_pkg::SZ_B ? eau_pkg::STEP_B : eau_pkg::STEP_W;
    if (s == eau_pkg::SZ_L) st = eau_pkg::STEP_L;
    br = c >= eau_pkg::CLS_BCC && c <= eau_pkg::CLS_JSR;
    rm = m >= eau_pkg::M_RIND && m <= eau_pkg::M_PDEC;
    k = br ? eau_pkg::K_BR : eau_pkg::K_MEM;
    ea = rv;
    wb = rv;
    im = e;
    case (m)
      eau_pkg::M_RD: k = eau_pkg::K_REG;
      eau_pkg::M_D16: ea = rv + {{16{e[15]}}, e[15:0]};
      eau_pkg::M_D32: ea = rv + e;
      eau_pkg::M_PINC: wb = rv + st;
      eau_pkg::M_PDEC: begin
        ea = rv - st;
        wb = ea;
      end
      eau_pkg::M_A8: ea = {24'hffffff, e[7:0]};
      eau_pkg::M_A16: ea = {{16{e[15]}}, e[15:0]};
      eau_pkg::M_A24: ea = {8'h00, e[23:0]};
      eau_pkg::M_A32: ea = e;
      eau_pkg::M_I8: im = {24'h0, e[7:0]};
      eau_pkg::M_I16: im = {16'h0, e[15:0]};
      eau_pkg::M_PC8: ea = {8'h00, p + {{16{e[7]}}, e[7:0]}};
      eau_pkg::M_PC16: ea = {8'h00, p + {{8{e[15]}}, e[15:0]}};
      eau_pkg::M_MIND: ea = {8'h00, part.mem_val[23:0]};
      default: ;
    endcase
    if (m >= eau_pkg::M_I8 && m <= eau_pkg::M_I32) k = eau_pkg::K_IMM;
    if (br) ea[31:24] = 8'h00;
    if (br || s != eau_pkg::SZ_B) ea[0] = 1'b0;
    do_op({c, m, f, r}, e, p);
    cmp_lat(lat, rm ? 4 : (m == eau_pkg::M_MIND ? 4 + mdel : 2), "latency");
    cmp_val(ill, 1'b0, "refused");
    cmp_val(ea_kind, k, "kind");
    cmp_val(ea_size, s, "size");
    if (k == eau_pkg::K_IMM) cmp_val(imm_data, im, "immediate");
    else if (k == eau_pkg::K_REG) cmp_val(reg_field, r, "reg field");
    else cmp_val(ea_addr, ea, "address");
    cmp_val(wbv, m == eau_pkg::M_PINC || m == eau_pkg::M_PDEC, "wb pulse");
    if (wbv) cmp_val(wb_data, wb, "wb data");
    if (wbv) cmp_val(wb_index, r[2:0], "wb index");
    cmp_val(bz, 1'b1, "busy");
    cmp_val(insn_len, m inside {eau_pkg::M_D16, eau_pkg::M_A16, eau_pkg::M_I16, eau_pkg::M_PC16}
      ? 2 : m inside {eau_pkg::M_D32, eau_pkg::M_A24, eau_pkg::M_A32, eau_pkg::M_I32} ? 3 : 1,
      "length");
    if (rm) cmp_val(ridx, r[2:0], "reg index");
    if (m == eau_pkg::M_MIND) cmp_val(maddr, {24'h0, e[7:1], 1'b0}, "pointer");
    if (c == eau_pkg::CLS_BIT) cmp_val(bit_num, f[2:0], "bit number");
    if (c == eau_pkg::CLS_TRAP) cmp_val(trap_vec, f[1:0], "vector");
    last_ea = ea;
  endtask
  task automatic run_ill(logic [3:0] c, logic [3:0] m, logic [1:0] s);
    do_op({c, m, s, 6'h01}, 32'h10, 24'h100);
    cmp_val(ill, 1'b1, "not refused");
    cmp_lat(lat, 2, "refusal");
  endtask
  initial begin
    void'($urandom(96763));
    for (int i = 0; i < 8; i++) part.regs[i] = $urandom;
    part.regs[3] = 32'h00001000;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus_rd(eau_pkg::A_CTRL, rb);
    cmp_val(rb, 32'h1, "ctrl reset");
    bus_wr(eau_pkg::A_CNT, 32'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_A16, 4'h4, 4'h0, 32'h8000, 24'h0);
    bus_rd(eau_pkg::A_LEA, rb);
    cmp_val(rb, last_ea, "last address");
    run_ill(eau_pkg::CLS_ALU, eau_pkg::M_A16, 2'h0);
    bus_rd(eau_pkg::A_STAT, rb);
    cmp_val(rb, {15'h0, 1'b1, 4'h0, eau_pkg::CLS_ALU, eau_pkg::M_A16, 4'h0}, "status");
    bus_wr(eau_pkg::A_CTRL, 32'h0);
    @(posedge ref_clk);
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus_wr(eau_pkg::A_CTRL, 32'h1);
    bus_rd(eau_pkg::A_CNT, rb);
    cmp_val(rb, 32'h00010001, "counts");
    bus_wr(4'h2, 32'hffffffff);
    bus_rd(4'h2, rb);
    cmp_val(rb, 32'h0, "unmapped");
    $display("register test done");
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_A8, 4'h0, 4'h3, 32'h01, 24'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_A8, 4'h8, 4'h3, 32'h01, 24'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_A16, 4'h0, 4'h3, 32'h7fff, 24'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_A32, 4'h0, 4'h3, 32'hffffffff, 24'h0);
    run_op(eau_pkg::CLS_JMP, eau_pkg::M_A24, 4'h0, 4'h3, 32'h00123457, 24'h0);
    run_op(eau_pkg::CLS_BCC, eau_pkg::M_PC8, 4'h0, 4'h0, 32'h80, 24'h000100);
    run_op(eau_pkg::CLS_BSR, eau_pkg::M_PC16, 4'h0, 4'h0, 32'h4, 24'hfffffe);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_D16, 4'h4, 4'h3, 32'hffff, 24'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_PDEC, 4'h8, 4'h3, 32'h0, 24'h0);
    run_op(eau_pkg::CLS_MOV, eau_pkg::M_PINC, 4'h0, 4'h3, 32'h0, 24'h0);
    for (int i = 0; i < 3; i++)
      run_op(eau_pkg::CLS_ALU, eau_pkg::M_I8 + 4'(i), 4'h8, 4'h1, 32'h89abcdef,
        24'h0);
    run_op(eau_pkg::CLS_BIT, eau_pkg::M_RD, 4'h5, 4'h9, 32'h0, 24'h0);
    run_op(eau_pkg::CLS_TRAP, eau_pkg::M_RD, 4'h3, 4'h0, 32'h0, 24'h0);
    part.mem_val = 32'hab123457;
    run_op(eau_pkg::CLS_JSR, eau_pkg::M_MIND, 4'h0, 4'h0, 32'hff, 24'h0);
    mdel = 3;
    run_op(eau_pkg::CLS_JMP, eau_pkg::M_MIND, 4'h4, 4'h0, 32'h41, 24'h0);
    $display("directed test done");
    run_ill(eau_pkg::CLS_MOV, eau_pkg::M_PC8, 2'h0);
    run_ill(eau_pkg::CLS_MOV, eau_pkg::M_MIND, 2'h0);
    run_ill(eau_pkg::CLS_BCC, eau_pkg::M_RD, 2'h0);
    run_ill(eau_pkg::CLS_JMP, eau_pkg::M_D16, 2'h0);
    run_ill(eau_pkg::CLS_TRAP, eau_pkg::M_RIND, 2'h0);
    run_ill(eau_pkg::CLS_MOV, eau_pkg::M_A32, 2'h3);
    $display("refusal test done");
    for (int i = 0; i < 300; i++) begin
      logic [3:0] m, c, f, r;
      logic j;
      m = 4'($urandom_range(15));
      f = {2'($urandom_range(2)), 2'($urandom)};
      r = 4'($urandom);
      j = 1'($urandom);
      c = eau_pkg::CLS_MOV;
      if (m inside {eau_pkg::M_A24, eau_pkg::M_MIND} || (m == eau_pkg::M_RIND && j))
        c = j ? eau_pkg::CLS_JMP : eau_pkg::CLS_JSR;
      if (m inside {eau_pkg::M_PC8, eau_pkg::M_PC16}) c = j ? eau_pkg::CLS_BCC : eau_pkg::CLS_BSR;
      @(posedge ref_clk);
      #1;
      part.regs[r[2:0]] = $urandom;
      if (m inside {eau_pkg::M_PINC, eau_pkg::M_PDEC} && f[3:2] != 2'h0)
        part.regs[r[2:0]][0] = 1'b0;
      part.mem_val = $urandom;
      mdel = $urandom_range(3);
      run_op(c, m, f, r, $urandom, 24'($urandom));
    end
    $display("random test done");
    complete_run;
  end
endmodule
